// ### verilog/dpoc_top.sv
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "dpoc_params.svh"

module dpoc_top #(
	parameter int TICK_CYCLES = `DPOC_TICK_NS / `DPOC_CLK_NS
) (
	input wire logic clk,
	input wire logic nrst,
	input wire dpoc_pkg::dpoc_meas_t meas,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic [3:0] start,
	output logic [3:0] trip,
	output logic mem_active,
	output logic irq
);

	// ==========================================================
	// Helpers
	function automatic logic signed [9:0] ang_wrap(input logic signed [10:0] a);
		logic signed [10:0] r;
		r = a;
		if (r > 11'sd179) begin
			r = r - 11'sd360;
		end else if (r < -11'sd180) begin
			r = r + 11'sd360;
		end
		return r[9:0];
	endfunction

	function automatic logic in_sector(input logic signed [9:0] a);
		logic signed [9:0] lim;
		lim = `DPOC_SECTOR;
		return (a <= lim) && (a >= -lim);
	endfunction

	// ==========================================================
	// Time base
	logic [31:0] div_cnt;
	logic [3:0] mem_sub;
	wire tick = (div_cnt == 32'(TICK_CYCLES - 1));
	wire mem_tick = tick && (mem_sub == `DPOC_MEM_STEP_TICKS - 4'h1);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt <= 32'h0;
			mem_sub <= 4'h0;
		end else begin
			div_cnt <= tick ? 32'h0 : div_cnt + 32'h1;
			if (tick) begin
				mem_sub <= mem_tick ? 4'h0 : mem_sub + 4'h1;
			end
		end
	end

	// ==========================================================
	// Registers
	logic [5:0] depth;
	logic [7:0] irq_stat;
	logic [7:0] irq_mask;
	dpoc_pkg::dpoc_stage_cfg_t cfg [0:3];

	wire wr_ctrl = wr && (addr == `DPOC_CTRL);
	wire wr_stat = wr && (addr == `DPOC_IRQ_STAT);
	wire wr_mask = wr && (addr == `DPOC_IRQ_MASK);
	// Depth writes outside the supported range are clamped rather than ignored, so
	// software always reads back the depth in force.
	wire [5:0] depth_wr = (wdata[5:0] < 6'h02) ? 6'h02 : (wdata[5:0] > 6'h20) ? 6'h20 : wdata[5:0];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			depth <= `DPOC_DEPTH_RST;
			irq_mask <= 8'h00;
		end else begin
			if (wr_ctrl) begin
				depth <= depth_wr;
			end
			if (wr_mask) begin
				irq_mask <= wdata[7:0];
			end
		end
	end

	// ==========================================================
	// Measurement front end
	wire [15:0] i01 = (meas.i_mag[0] > meas.i_mag[1]) ? meas.i_mag[0] : meas.i_mag[1];
	wire [15:0] imax = (i01 > meas.i_mag[2]) ? i01 : meas.i_mag[2];
	wire [15:0] imax_sat = (imax > `DPOC_I_SAT) ? `DPOC_I_SAT : imax;
	wire [2:0] ull_low;
	wire [2:0] ull_ok;
	genvar k;
	for (k = 0; k < 3; k++) begin : g_ull
		assign ull_low[k] = meas.ull_mag[k] < `DPOC_U_1PCT;
		assign ull_ok[k] = meas.ull_mag[k] >= `DPOC_U_MIN;
	end
	wire collapsed = &ull_low;
	wire u_ok = |ull_ok;
	wire [1:0] ph = (meas.fault_ph == 2'h3) ? 2'h0 : meas.fault_ph;
	wire [8:0] cur_ang = meas.ln_fault ? meas.i_ang[ph] : meas.i1_ang;
	wire [8:0] live_ref = meas.ln_fault ? meas.healthy_ang[ph] : meas.u1_ang;

	// ==========================================================
	// Voltage memory
	// The history freezes while voltages are collapsed, so the entry read back
	// is always the one written depth-1 memory steps before the last write ahead of the collapse.
	logic [8:0] mem [0:31];
	logic [4:0] wr_ptr;
	logic [5:0] hold_cnt;
	logic [5:0] fill_cnt;
	wire [4:0] rd_ptr = wr_ptr - depth[4:0];
	wire [8:0] mem_ang = mem[rd_ptr];
	// Until depth entries are recorded after reset the history holds no valid angle,
	// so a collapse that early loses the direction at once.
	wire mem_ready = fill_cnt >= depth;
	wire mem_expired = !mem_ready || (hold_cnt >= depth);

	always_ff @(posedge clk) begin
		if (mem_tick && !collapsed) begin
			mem[wr_ptr] <= meas.u1_ang;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr <= 5'h00;
			hold_cnt <= 6'h00;
			fill_cnt <= 6'h00;
		end else begin
			if (mem_tick && !collapsed) begin
				wr_ptr <= wr_ptr + 5'h01;
				fill_cnt <= (fill_cnt == 6'h20) ? fill_cnt : fill_cnt + 6'h01;
			end
			// The hold count stops at the depth, so expiry stays until voltages return.
			if (!collapsed) begin
				hold_cnt <= 6'h00;
			end else if (mem_tick && !mem_expired) begin
				hold_cnt <= hold_cnt + 6'h01;
			end
		end
	end

	wire [8:0] ref_ang = collapsed ? mem_ang : live_ref;
	wire dir_valid = collapsed ? !mem_expired : u_ok;
	// Fault angle
	wire signed [9:0] fault_ang = ang_wrap(11'(signed'(cur_ang)) - 11'(signed'(ref_ang)));

	// ==========================================================
	// Stages
	wire [3:0] cond;
	wire [3:0] over;
	wire [3:0] sect;
	wire [3:0] elapsed;
	logic [15:0] dt_cnt [0:3];
	logic [31:0] inv_acc [0:3];

	for (k = 0; k < 4; k++) begin : g_stg
		wire [15:0] excess = imax_sat - cfg[k].thr;
		wire signed [9:0] rel = ang_wrap(11'(fault_ang) - 11'(signed'(cfg[k].base)));
		wire nondir = cfg[k].mode == dpoc_pkg::DPOC_NONDIR;
		wire backup = (cfg[k].mode == dpoc_pkg::DPOC_DIRBACK) && collapsed && mem_expired;
		wire cfg_hit = wr && (addr == 8'(`DPOC_STG_BASE + 8 * k));
		wire dly_hit = wr && (addr == 8'(`DPOC_STG_BASE + 8 * k + 4));
		assign over[k] = imax_sat > cfg[k].thr;
		assign sect[k] = in_sector(rel);
		assign cond[k] = over[k] && (nondir || backup || (dir_valid && sect[k]));
		// Delay select
		// Trip is taken when the count reaches the delay, so a zero delay trips at once.
		assign elapsed[k] = cfg[k].inv ? (inv_acc[k][31:8] >= 24'(cfg[k].delay)) :
			(dt_cnt[k] >= cfg[k].delay);

		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				cfg[k] <= '{`DPOC_THR_RST, 9'h000, dpoc_pkg::DPOC_DIR, 1'b0, `DPOC_DLY_RST};
			end else if (cfg_hit) begin
				cfg[k].thr <= wdata[`DPOC_CFG_BASE_LSB-1:`DPOC_CFG_THR_LSB];
				cfg[k].base <= wdata[`DPOC_CFG_BASE_LSB+8:`DPOC_CFG_BASE_LSB];
				cfg[k].mode <= dpoc_pkg::dpoc_mode_t'(wdata[`DPOC_CFG_MODE_LSB+1:`DPOC_CFG_MODE_LSB]);
				cfg[k].inv <= (k < 2) && wdata[`DPOC_CFG_INV_BIT];
			end else if (dly_hit) begin
				cfg[k].delay <= wdata[15:0];
			end
		end

		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				dt_cnt[k] <= 16'h0000;
				inv_acc[k] <= 32'h0;
			end else if (!cond[k]) begin
				dt_cnt[k] <= 16'h0000;
				inv_acc[k] <= 32'h0;
			end else if (tick) begin
				// Both timers saturate instead of wrapping, so a long start keeps its trip.
				dt_cnt[k] <= (&dt_cnt[k]) ? dt_cnt[k] : dt_cnt[k] + 16'h0001;
				inv_acc[k] <= (&inv_acc[k][31:24]) ? inv_acc[k] : inv_acc[k] + 32'(excess);
			end
		end
	end

	wire [3:0] next_trip = cond & elapsed;
	wire [7:0] events = {next_trip & ~trip, cond & ~start};
	wire [7:0] next_irq_stat = (irq_stat & ~(wr_stat ? wdata[7:0] : 8'h00)) | events;
	wire [7:0] next_irq_mask = wr_mask ? wdata[7:0] : irq_mask;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			start <= 4'h0;
			trip <= 4'h0;
			mem_active <= 1'b0;
			irq_stat <= 8'h00;
			irq <= 1'b0;
		end else begin
			start <= cond;
			trip <= next_trip;
			mem_active <= collapsed && !mem_expired;
			irq_stat <= next_irq_stat;
			irq <= |(next_irq_stat & next_irq_mask);
		end
	end

	// ==========================================================
	// Read back
	// Unmapped addresses read as zero, and rdata falls back to zero after each read.
	wire [7:0] stg_off = addr - `DPOC_STG_BASE;
	wire [1:0] stg_sel = stg_off[4:3];
	wire [31:0] stg_word = stg_off[2] ? {16'h0000, cfg[stg_sel].delay} :
		{4'h0, cfg[stg_sel].inv, cfg[stg_sel].mode, cfg[stg_sel].base, cfg[stg_sel].thr};
	wire [31:0] rd_word =
		(addr == `DPOC_CTRL) ? {26'h0, depth} :
		(addr == `DPOC_STATUS) ? {22'h0, mem_expired, mem_active, trip, start} :
		(addr == `DPOC_IRQ_STAT) ? {24'h0, irq_stat} :
		(addr == `DPOC_IRQ_MASK) ? {24'h0, irq_mask} :
		(stg_off < 8'h20 && addr[1:0] == 2'h0) ? stg_word : 32'h0;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 32'h0;
		end else begin
			rdata <= rd ? rd_word : 32'h0;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_max_phase: assert property (imax >= meas.i_mag[0] && imax >= meas.i_mag[1] &&
		imax >= meas.i_mag[2]) else $error("largest phase current not selected");
	a_seq_pair: assert property (!meas.ln_fault && !collapsed |->
		ref_ang == meas.u1_ang && cur_ang == meas.i1_ang) else $error("sequence pair wrong");
	a_earth_pair: assert property (meas.ln_fault && !collapsed |->
		ref_ang == meas.healthy_ang[ph]) else $error("healthy voltage not used");
	a_sector_bound: assert property (cond[0] && cfg[0].mode == dpoc_pkg::DPOC_DIR |->
		sect[0] && dir_valid) else $error("directional start outside sector");
	a_trip_start: assert property ((trip & ~start) == 4'h0)
		else $error("trip without start");
	a_mem_ref: assert property (collapsed && !mem_expired |-> ref_ang == mem_ang)
		else $error("memory angle not used");
	a_nondir_start: assert property (cfg[1].mode == dpoc_pkg::DPOC_NONDIR && over[1] |=>
		start[1]) else $error("non-directional stage did not start");
	a_backup_start: assert property (cfg[0].mode == dpoc_pkg::DPOC_DIRBACK && over[0] &&
		collapsed && mem_expired |=> start[0]) else $error("backup did not start");
	a_fixed_only: assert property (!cfg[2].inv && !cfg[3].inv)
		else $error("inverse delay on a high stage");
	a_sat_ceiling: assert property (imax_sat <= `DPOC_I_SAT)
		else $error("current above ceiling");
	a_low_volt: assert property (!collapsed && !u_ok |-> !dir_valid)
		else $error("direction from low voltage");
	a_drop_clears: assert property ($fell(start[0]) |-> !trip[0] && dt_cnt[0] == 16'h0000)
		else $error("timing not cancelled");
	a_stage_write: assert property (wr && addr == 8'(`DPOC_STG_BASE + 8'h08) |=>
		cfg[1].thr == $past(wdata[15:0])) else $error("stage setting write lost");
	a_fixed_delay: assert property (trip[0] && !$past(cfg[0].inv) |->
		$past(dt_cnt[0]) >= $past(cfg[0].delay)) else $error("trip before delay");
	a_history_write: assert property (mem_tick && !collapsed |=>
		mem[$past(wr_ptr)] == $past(meas.u1_ang)) else $error("angle history not recorded");

	c_trip: cover property (start[0] ##[1:1000] trip[0]);
	c_mem_hold: cover property (mem_active ##1 !mem_active && collapsed);
	c_irq: cover property ($rose(irq));
	c_inverse: cover property (cfg[0].inv && trip[0]);
	c_backup: cover property (collapsed && mem_expired && start[2]);

endmodule

`default_nettype wire

// ### verilog/dpoc_params.svh
`ifndef DPOC_PARAMS_SVH
`define DPOC_PARAMS_SVH

// ==========================================================
// Timing
`define DPOC_CLK_NS 5
`define DPOC_TICK_NS 10000000
`define DPOC_MEM_STEP_TICKS 4'ha

// ==========================================================
// Measurement scaling
`define DPOC_I_RATED 16'h0100
`define DPOC_I_SAT 16'h3200
`define DPOC_U_1PCT 16'h0064
`define DPOC_U_MIN 16'h00c8
`define DPOC_SECTOR 10'h058

// ==========================================================
// Register map
`define DPOC_CTRL 8'h00
`define DPOC_STATUS 8'h04
`define DPOC_IRQ_STAT 8'h08
`define DPOC_IRQ_MASK 8'h0c
`define DPOC_STG_BASE 8'h10
`define DPOC_CFG_THR_LSB 0
`define DPOC_CFG_BASE_LSB 16
`define DPOC_CFG_MODE_LSB 25
`define DPOC_CFG_INV_BIT 27
`define DPOC_DEPTH_RST 6'h0a
`define DPOC_THR_RST 16'h0100
`define DPOC_DLY_RST 16'h0004

`endif

// ### verilog/dpoc_pkg.sv
package dpoc_pkg;
	typedef enum logic [1:0] {
		DPOC_DIR,
		DPOC_NONDIR,
		DPOC_DIRBACK
	} dpoc_mode_t;

	typedef struct packed {
		logic [2:0][15:0] i_mag;
		logic [2:0][8:0] i_ang;
		logic [8:0] i1_ang;
		logic [8:0] u1_ang;
		logic [2:0][15:0] ull_mag;
		logic [2:0][8:0] healthy_ang;
		logic ln_fault;
		logic [1:0] fault_ph;
	} dpoc_meas_t;

	typedef struct packed {
		logic [15:0] thr;
		logic [8:0] base;
		dpoc_mode_t mode;
		logic inv;
		logic [15:0] delay;
	} dpoc_stage_cfg_t;
endpackage

// ### verif/dpoc_meas_model.sv
`timescale 1ns/100ps
`default_nettype none

module dpoc_meas_model (
	input wire logic [15:0] amp,
	input wire logic [1:0] ph,
	input wire logic [8:0] ang,
	input wire logic [15:0] u,
	input wire logic ln,
	output var dpoc_pkg::dpoc_meas_t meas
);
	// Unused current angles and collapsed references read -180 degrees, so a wrong path never looks healthy.
	localparam logic [8:0] BAD = 9'h14c;
	logic dead;

	assign dead = u < 16'h0064;

	always_comb begin
		meas = '0;
		for (int k = 0; k < 3; k++) begin
			meas.i_mag[k] = (k == int'(ph)) ? amp : amp >> 2;
			meas.i_ang[k] = (ln && k == int'(ph)) ? ang : BAD;
			meas.ull_mag[k] = u;
			meas.healthy_ang[k] = dead ? BAD : 9'h000;
		end
		meas.i1_ang = ln ? BAD : ang;
		meas.u1_ang = dead ? BAD : 9'h000;
		meas.ln_fault = ln;
		meas.fault_ph = ph;
	end
endmodule

`default_nettype wire

// ### verif/dpoc_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "dpoc_params.svh"

module dpoc_top_tb_top;
	localparam int TC = 20;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] amp = 16'h0;
	logic [1:0] ph = 2'h0;
	logic [8:0] ang = 9'h000;
	logic [15:0] u = 16'h2710;
	logic ln = 1'b0;
	dpoc_pkg::dpoc_meas_t meas;
	logic [31:0] rdata;
	logic [3:0] start;
	logic [3:0] trip;
	logic mem_active;
	logic irq;
	int mismatches = 0;
	int check_count = 0;

	always #2.5 clk = ~clk;

	dpoc_meas_model dpoc_meas_model_inst (.amp(amp), .ph(ph), .ang(ang), .u(u), .ln(ln),
		.meas(meas));
	dpoc_top #(.TICK_CYCLES(TC)) dpoc_top_inst (.clk(clk), .nrst(nrst), .meas(meas),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .start(start),
		.trip(trip), .mem_active(mem_active), .irq(irq));

	// ==========================================================
	// Shared tasks
	task automatic stop_test();
		if (mismatches == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, s);
			mismatches++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic creg(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(n, rdata, e);
	endtask

	task automatic cfg(input int s, input logic [8:0] b, input dpoc_pkg::dpoc_mode_t m,
		input logic v, input logic [15:0] dl);
		wreg(8'(`DPOC_STG_BASE + 8 * s), {4'h0, v, m, b, `DPOC_THR_RST});
		wreg(8'(`DPOC_STG_BASE + 8 * s + 4), {16'h0, dl});
	endtask

	task automatic flt(input logic [15:0] a, input logic [1:0] p, input logic [8:0] g,
		input logic [15:0] v, input logic l);
		@(posedge clk);
		amp <= a;
		ph <= p;
		ang <= g;
		u <= v;
		ln <= l;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		creg("depth", `DPOC_CTRL, 32'h0a); // Default.
		creg("dly3", 8'h2c, 32'h04); // Default.
		creg("mask", `DPOC_IRQ_MASK, 32'h0);
		wreg(8'h40, 32'hffffffff);
		creg("hole", 8'h40, 32'h0);
		wreg(8'h20, 32'h08000100);
		creg("inv2", 8'h20, 32'h0100); // Fixed only.
		wreg(8'h10, 32'h08000100);
		creg("inv0", 8'h10, 32'h08000100); // Inverse kept.
		creg("cfg1", 8'h18, 32'h0100); // Independent.
		wreg(`DPOC_CTRL, 32'h0);
		creg("dmin", `DPOC_CTRL, 32'h02); // Clamp low.
		wreg(`DPOC_CTRL, 32'h3f);
		creg("dmax", `DPOC_CTRL, 32'h20); // Clamp high.
	endtask

	task automatic t_dt();
		cfg(0, 9'h000, dpoc_pkg::DPOC_DIR, 1'b0, 16'h0004);
		flt(16'h0101, 2'h2, 9'h059, 16'h2710, 1'b0);
		cyc(3);
		chk("out", start, 4'h0); // Sector edge.
		flt(16'h0100, 2'h2, 9'h058, 16'h2710, 1'b0);
		cyc(3);
		chk("eq", start, 4'h0); // Must exceed.
		flt(16'h0101, 2'h2, 9'h058, 16'h2710, 1'b0);
		cyc(1);
		chk("in", start, 4'hf); // Largest phase.
		cyc(2 * TC);
		flt(16'h0, 2'h2, 9'h058, 16'h2710, 1'b0);
		cyc(1);
		chk("drop", start, 4'h0); // Release.
		flt(16'h0101, 2'h2, 9'h058, 16'h2710, 1'b0);
		cyc(3 * TC);
		chk("early", trip, 4'h0); // Restarted timing.
		cyc(2 * TC + 2);
		chk("trip", trip, 4'hf); // Fixed delay.
		flt(16'h0, 2'h2, 9'h058, 16'h2710, 1'b0);
		cyc(1);
		chk("off", {start, trip}, 8'h0); // Release.
	endtask

	task automatic t_irq();
		wreg(`DPOC_IRQ_STAT, 32'hff);
		flt(16'h0101, 2'h0, 9'h000, 16'h2710, 1'b0);
		cyc(2);
		chk("irqm", irq, 1'b0);
		creg("stat", `DPOC_IRQ_STAT, 32'h0f);
		wreg(`DPOC_IRQ_MASK, 32'h01);
		cyc(2);
		chk("irq", irq, 1'b1);
		wreg(`DPOC_IRQ_STAT, 32'h01);
		cyc(2);
		chk("irqc", irq, 1'b0);
		wreg(`DPOC_IRQ_MASK, 32'h10);
		cyc(5 * TC);
		chk("irqt", irq, 1'b1);
		creg("stat2", `DPOC_IRQ_STAT, 32'hfe);
		flt(16'h0, 2'h0, 9'h000, 16'h2710, 1'b0);
		wreg(`DPOC_IRQ_MASK, 32'h0);
	endtask

	task automatic t_modes();
		logic [8:0] ag [5] = '{9'h0b3, 9'h000, 9'h05b, 9'h000, 9'h14c};
		logic lf [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
		logic [3:0] ex [5] = '{4'ha, 4'h7, 4'h2, 4'h7, 4'ha};
		cfg(0, 9'h000, dpoc_pkg::DPOC_DIR, 1'b0, 16'h0fff);
		cfg(1, 9'h000, dpoc_pkg::DPOC_NONDIR, 1'b0, 16'h0fff);
		cfg(2, 9'h000, dpoc_pkg::DPOC_DIRBACK, 1'b0, 16'h0fff);
		cfg(3, 9'h14c, dpoc_pkg::DPOC_DIR, 1'b0, 16'h0fff);
		for (int k = 0; k < 5; k++) begin
			flt(16'h0200, 2'(k % 3), ag[k], 16'h2710, lf[k]);
			cyc(1);
			chk("mode", start, ex[k]); // Angle paths.
		end
	endtask

	task automatic t_volt();
		wreg(`DPOC_CTRL, 32'h0);
		// Let at least two memory steps be recorded before the first collapse.
		cyc(20 * TC);
		flt(16'h0200, 2'h0, 9'h000, 16'h00c7, 1'b0);
		cyc(2);
		chk("u199", start & 4'h3, 4'h2); // Too low.
		flt(16'h0200, 2'h0, 9'h000, 16'h00c8, 1'b0);
		cyc(2);
		chk("u200", start & 4'h3, 4'h3); // Enough.
		flt(16'h0200, 2'h0, 9'h000, 16'h0032, 1'b0);
		cyc(3);
		chk("mem", {mem_active, start}, 5'h17); // Remembered angle.
		cyc(10 * TC - 15);
		chk("hold", mem_active, 1'b1); // Still held.
		cyc(12 * TC);
		chk("lost", {mem_active, start}, 5'h06); // Backup takes over.
		flt(16'h0, 2'h0, 9'h000, 16'h2710, 1'b0);
		cyc(2);
	endtask

	task automatic t_inv();
		cfg(0, 9'h000, dpoc_pkg::DPOC_NONDIR, 1'b1, 16'h00c4);
		flt(16'hffff, 2'h0, 9'h000, 16'h2710, 1'b0);
		cyc(3 * TC - 2);
		chk("inv", trip[0], 1'b0); // Saturated rate.
		cyc(2 * TC + 5);
		chk("invt", trip[0], 1'b1); // Saturated rate.
		flt(16'h0, 2'h0, 9'h000, 16'h2710, 1'b0);
	endtask

	// ==========================================================
	// Sequence
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		cyc(1);
		chk("rst", {start, trip, irq, mem_active}, 10'h0);
		t_regs();
		t_dt();
		t_irq();
		t_modes();
		t_volt();
		t_inv();
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		stop_test();
	end
endmodule

`default_nettype wire
